// [hdl/rcf_cfg.svh]
// Purpose: constants of the reset cause flag block
// Assumes: included by the package and by every design module
// Notes:   definitions only
`ifndef RCF_CFG_SVH
`define RCF_CFG_SVH

// bus widths
`define RCF_AW          8
`define RCF_DW          32
`define RCF_SW          4

// register byte offsets
`define RCF_OFS_CAUSE   8'h94
`define RCF_OFS_ISTAT   8'h00
`define RCF_OFS_IEN     8'h04
`define RCF_OFS_ICLR    8'h08

// cause flag vector: index inside the five-bit vector
`define RCF_NCAUSE      5
`define RCF_F_PIN       0
`define RCF_F_PWR       1
`define RCF_F_SW        2
`define RCF_F_WDG       3
`define RCF_F_LOCK      4

// field positions in the cause register
`define RCF_FLAG_LSB    26
`define RCF_FLAG_MSB    30
`define RCF_FLAG_MASK   32'h7c000000
`define RCF_RMV_BIT     23
`define RCF_RMV_LANE    2
`define RCF_IRQ_LANE    0

// reset values
`define RCF_FLAGS_RST   5'h03
`define RCF_CAUSE_RST   32'h0c000000

// answers on the bus
`define RCF_RESP_OKAY   2'h0
`define RCF_RESP_SLVERR 2'h2

`endif

// [hdl/rcf_pkg.sv]
// Purpose: types shared by the reset cause flag modules
// Assumes: rcf_cfg.svh gives all widths
// Notes:   address decode lives here since read and write both use it
package rcf_pkg;
`include "rcf_cfg.svh"

    // register selected by an address
    typedef enum logic [2:0] {
        RCF_SEL_NONE,
        RCF_SEL_CAUSE,
        RCF_SEL_ISTAT,
        RCF_SEL_IEN,
        RCF_SEL_ICLR
    } rcf_sel_t;

    // reset events coming from the reset controller, high while active
    typedef struct packed {
        logic lockup;
        logic watchdog;
        logic software;
        logic brownout;
        logic pin;
    } rcf_evt_t;

    // state of the flag core
    typedef struct packed {
        logic [`RCF_NCAUSE-1:0] flags;
        logic                   rmv;
    } rcf_core_st_t;

    // state of the top: bus slave, clear request and interrupt logic
    typedef struct packed {
        logic                   aw_have;
        logic                   w_have;
        logic [`RCF_AW-1:0]     awaddr;
        logic [`RCF_DW-1:0]     wdata;
        logic [`RCF_SW-1:0]     wstrb;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   ar_have;
        logic [`RCF_AW-1:0]     araddr;
        logic                   arready;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [`RCF_DW-1:0]     rdata;
        logic                   clr_req;
        logic [`RCF_NCAUSE-1:0] istat;
        logic [`RCF_NCAUSE-1:0] ien;
        logic                   irq;
    } rcf_top_st_t;

    // word-aligned address decode
    function automatic rcf_sel_t rcf_decode(input logic [`RCF_AW-1:0] a);
        rcf_sel_t s;
        s = RCF_SEL_NONE;
        if (a[`RCF_AW-1:2] == `RCF_OFS_CAUSE >> 2)
            s = RCF_SEL_CAUSE;
        else if (a[`RCF_AW-1:2] == `RCF_OFS_ISTAT >> 2)
            s = RCF_SEL_ISTAT;
        else if (a[`RCF_AW-1:2] == `RCF_OFS_IEN >> 2)
            s = RCF_SEL_IEN;
        else if (a[`RCF_AW-1:2] == `RCF_OFS_ICLR >> 2)
            s = RCF_SEL_ICLR;
        return s;
    endfunction

endpackage

// [hdl/rcf_flag_core.sv]
// Purpose: sticky reset cause flags with a self-clearing remove request
// Assumes: events are synchronous levels, high while their reset is active
// Notes:   only power_on_reset_n restores the flags; aresetn leaves them alone
`timescale 1ns/1ps
`include "rcf_cfg.svh"
module rcf_flag_core
    import rcf_pkg::*;
(
    input  wire logic                   aclk,             // system clock
    input  wire logic                   aresetn,          // system reset, sync, low
    input  wire logic                   power_on_reset_n, // power-on reset, sync, low
    input  wire rcf_evt_t               ev,               // reset events
    input  wire logic                   clear_req,        // one-cycle remove request
    output logic [`RCF_NCAUSE-1:0]      flags             // cause flags, registered
);
    rcf_core_st_t           st_q;
    rcf_core_st_t           st_d;
    logic [`RCF_NCAUSE-1:0] set_v;

    // next state; a new event beats a clear in the same cycle
    always_comb begin
        set_v              = '0;
        set_v[`RCF_F_LOCK] = ev.lockup;
        set_v[`RCF_F_WDG]  = ev.watchdog;
        set_v[`RCF_F_SW]   = ev.software;
        set_v[`RCF_F_PWR]  = ev.brownout;
        set_v[`RCF_F_PIN]  = |ev;                // pin flag follows every reset
        st_d       = st_q;
        st_d.rmv   = clear_req;                  // lives one cycle only
        st_d.flags = (st_q.rmv ? '0 : st_q.flags) | set_v;
        if (!aresetn) begin
            st_d.rmv = 1'b0;                     // flags survive warm resets
        end
        if (!power_on_reset_n) begin
            st_d.rmv   = 1'b0;
            st_d.flags = `RCF_FLAGS_RST;
        end
    end

    // single state register
    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end

    assign flags = st_q.flags;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!power_on_reset_n);

    a_por_load: assert property (disable iff (1'b0)
        !power_on_reset_n |=> st_q.flags == `RCF_FLAGS_RST)
        else $error("flags not loaded by power-on reset");
    a_warm_keep: assert property (
        (!aresetn && !st_q.rmv && !(|ev)) |=> st_q.flags == $past(st_q.flags))
        else $error("warm reset changed flags");
    a_lockup_flag: assert property (
        ev.lockup |=> st_q.flags[`RCF_F_LOCK])
        else $error("lock-up flag not set");
    a_watchdog_flag: assert property (
        ev.watchdog |=> st_q.flags[`RCF_F_WDG])
        else $error("watchdog flag not set");
    a_soft_flag: assert property (
        ev.software |=> st_q.flags[`RCF_F_SW])
        else $error("software flag not set");
    a_power_flag: assert property (
        ev.brownout |=> st_q.flags[`RCF_F_PWR] && st_q.flags[`RCF_F_PIN])
        else $error("power flag not set");
    a_pin_any: assert property (
        (|ev) |=> st_q.flags[`RCF_F_PIN])
        else $error("pin flag not set after reset");
    a_clear_all: assert property (
        (clear_req && aresetn) ##1 !(|ev) |=> st_q.flags == '0)
        else $error("remove did not clear flags");
    a_rmv_self: assert property (
        (clear_req && aresetn) ##1 !clear_req |=> !st_q.rmv)
        else $error("remove request did not self-clear");
    a_flag_sticky: assert property (
        !st_q.rmv |=> (st_q.flags & $past(st_q.flags)) == $past(st_q.flags))
        else $error("flag dropped without remove");
endmodule

// [hdl/rcf_top.sv]
// Purpose: reset cause status register behind an AXI4-Lite slave
// Assumes: single clock; reset events are synchronous levels from the
//          reset controller; one write and one read outstanding at most
// Notes:   interrupt status, enable and clear registers flag cause events
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "rcf_cfg.svh"

module rcf_top
    import rcf_pkg::*;
(
    input  wire logic                   aclk,                 // system clock, 40 MHz
    input  wire logic                   aresetn,              // system reset, sync, low
    input  wire logic                   power_on_reset_n,     // power-on reset, sync, low
    input  wire logic                   cpu_lockup_rst,       // lock-up reset active
    input  wire logic                   watchdog_rst,         // watchdog reset active
    input  wire logic                   software_rst,         // system reset request
    input  wire logic                   brownout_rst,         // brown-out reset active
    input  wire logic                   external_reset_pin_n, // reset pin level, low
    input  wire logic [`RCF_AW-1:0]     s_axi_awaddr,         // write address
    input  wire logic [2:0]             s_axi_awprot,         // unused protection
    input  wire logic                   s_axi_awvalid,        // write address valid
    output logic                        s_axi_awready,        // write address ready
    input  wire logic [`RCF_DW-1:0]     s_axi_wdata,          // write data
    input  wire logic [`RCF_SW-1:0]     s_axi_wstrb,          // byte strobes
    input  wire logic                   s_axi_wvalid,         // write data valid
    output logic                        s_axi_wready,         // write data ready
    output logic [1:0]                  s_axi_bresp,          // write response
    output logic                        s_axi_bvalid,         // write response valid
    input  wire logic                   s_axi_bready,         // write response ready
    input  wire logic [`RCF_AW-1:0]     s_axi_araddr,         // read address
    input  wire logic [2:0]             s_axi_arprot,         // unused protection
    input  wire logic                   s_axi_arvalid,        // read address valid
    output logic                        s_axi_arready,        // read address ready
    output logic [`RCF_DW-1:0]          s_axi_rdata,          // read data
    output logic [1:0]                  s_axi_rresp,          // read response
    output logic                        s_axi_rvalid,         // read data valid
    input  wire logic                   s_axi_rready,         // read data ready
    output logic                        irq               // level interrupt
);
    rcf_top_st_t            st_q;
    rcf_top_st_t            st_d;
    rcf_evt_t               ev;
    logic [`RCF_NCAUSE-1:0] irq_ev;
    logic [`RCF_NCAUSE-1:0] flags;
    logic [`RCF_NCAUSE-1:0] clr_mask;
    logic [`RCF_DW-1:0]     rd_word;
    logic                   commit;
    rcf_sel_t               wsel;
    rcf_sel_t               rsel;

    // pack the reset events; the pin is active low at the port
    always_comb begin
        ev.lockup   = cpu_lockup_rst;
        ev.watchdog = watchdog_rst;
        ev.software = software_rst;
        ev.brownout = brownout_rst;
        ev.pin      = !external_reset_pin_n;
    end

    // interrupt sources: the pin bit fires only for a real pin reset
    always_comb begin
        irq_ev              = '0;
        irq_ev[`RCF_F_LOCK] = ev.lockup;
        irq_ev[`RCF_F_WDG]  = ev.watchdog;
        irq_ev[`RCF_F_SW]   = ev.software;
        irq_ev[`RCF_F_PWR]  = ev.brownout;
        irq_ev[`RCF_F_PIN]  = ev.pin;
    end

    // address decode of the held write and read addresses
    always_comb begin
        wsel   = rcf_decode(st_q.awaddr);
        rsel   = rcf_decode(st_q.araddr);
        commit = st_q.aw_have && st_q.w_have && !st_q.bvalid;
    end

    // read mux; reserved bits and the remove bit always read zero
    always_comb begin
        rd_word = '0;
        case (rsel)
            RCF_SEL_CAUSE: begin
                rd_word[`RCF_FLAG_MSB:`RCF_FLAG_LSB] = flags;
            end
            RCF_SEL_ISTAT: begin
                rd_word[`RCF_NCAUSE-1:0] = st_q.istat;
            end
            RCF_SEL_IEN: begin
                rd_word[`RCF_NCAUSE-1:0] = st_q.ien;
            end
            default: begin
                rd_word = '0;                     // clear register is write-only
            end
        endcase
    end

    // next state: bus slave, register writes and interrupt status
    always_comb begin
        st_d         = st_q;
        st_d.clr_req = 1'b0;
        clr_mask     = '0;

        // write channels are taken independently, in either order
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_have = 1'b1;
            st_d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_have = 1'b1;
            st_d.wdata  = s_axi_wdata;
            st_d.wstrb  = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        // both halves present: act on the write and answer it
        if (commit) begin
            st_d.aw_have = 1'b0;
            st_d.w_have  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = (wsel == RCF_SEL_NONE) ? `RCF_RESP_SLVERR : `RCF_RESP_OKAY;
            case (wsel)
                RCF_SEL_CAUSE: begin
                    // flags ignore the data; only a one in remove acts
                    st_d.clr_req = st_q.wstrb[`RCF_RMV_LANE]
                                   && st_q.wdata[`RCF_RMV_BIT];
                end
                RCF_SEL_IEN: begin
                    if (st_q.wstrb[`RCF_IRQ_LANE]) begin
                        st_d.ien = st_q.wdata[`RCF_NCAUSE-1:0];
                    end
                end
                RCF_SEL_ICLR: begin
                    if (st_q.wstrb[`RCF_IRQ_LANE]) begin
                        clr_mask = st_q.wdata[`RCF_NCAUSE-1:0];
                    end
                end
                default: begin
                    st_d.clr_req = 1'b0;          // status and unmapped: no effect
                end
            endcase
        end
        st_d.awready = !st_d.aw_have && !st_d.bvalid;
        st_d.wready  = !st_d.w_have && !st_d.bvalid;

        // read channel: data sampled one cycle after the address is taken
        if (s_axi_arvalid && st_q.arready) begin
            st_d.ar_have = 1'b1;
            st_d.araddr  = s_axi_araddr;
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (st_q.ar_have && !st_q.rvalid) begin
            st_d.ar_have = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rdata   = rd_word;
            st_d.rresp   = (rsel == RCF_SEL_NONE) ? `RCF_RESP_SLVERR : `RCF_RESP_OKAY;
        end
        st_d.arready = !st_d.ar_have && !st_d.rvalid;

        // sticky status: a new event wins over a clear in the same cycle
        st_d.istat = (st_q.istat & ~clr_mask) | irq_ev;
        st_d.irq   = |(st_d.istat & st_d.ien);

        // either reset returns the bus and interrupt state to idle
        if (!aresetn || !power_on_reset_n) begin
            st_d         = '0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
            st_d.arready = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end

    // flag storage sits on its own reset, see the core
    rcf_flag_core u_core (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .power_on_reset_n (power_on_reset_n),
        .ev               (ev),
        .clear_req        (st_q.clr_req),
        .flags            (flags)
    );

    // outputs straight from the state register
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign irq           = st_q.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !power_on_reset_n);

    a_rsv_zero: assert property (
        (st_q.ar_have && !st_q.rvalid && rsel == RCF_SEL_CAUSE)
        |=> s_axi_rvalid && (s_axi_rdata & ~`RCF_FLAG_MASK) == '0)
        else $error("reserved cause bits read nonzero");
    a_cause_read: assert property (
        (st_q.ar_have && !st_q.rvalid && rsel == RCF_SEL_CAUSE)
        |=> s_axi_rdata[`RCF_FLAG_MSB:`RCF_FLAG_LSB] == $past(flags))
        else $error("cause read does not show flags");
    a_flags_ro: assert property (
        (commit && wsel == RCF_SEL_CAUSE && !st_q.wdata[`RCF_RMV_BIT]
         && !$past(st_q.clr_req) && !(|ev))
        |=> flags == $past(flags))
        else $error("software write changed flags");
    a_rmv_issue: assert property (
        (commit && wsel == RCF_SEL_CAUSE && st_q.wstrb[`RCF_RMV_LANE]
         && st_q.wdata[`RCF_RMV_BIT]) |=> st_q.clr_req ##1 !st_q.clr_req)
        else $error("remove write not turned into one pulse");
    a_irq_level: assert property (
        ##1 irq == |(st_q.istat & st_q.ien))
        else $error("interrupt does not follow enabled status");
    a_bad_addr: assert property (
        (commit && wsel == RCF_SEL_NONE)
        |=> s_axi_bvalid && s_axi_bresp == `RCF_RESP_SLVERR)
        else $error("unmapped write not answered with error");
    a_read_turn: assert property (
        (s_axi_arvalid && s_axi_arready) |=> ##1 s_axi_rvalid)
        else $error("read not answered in two cycles");
endmodule

// [test/rcf_top_bench.sv]
// Purpose: self-checking bench of the reset cause flag block
// Assumes: bus outputs are registered, so ready and valid are read at the falling edge
// Notes:   random events and register actions follow a fixed seed
`timescale 1ns/1ps
`include "rcf_cfg.svh"
module rcf_top_bench
    import rcf_pkg::*;
;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

    logic                  aclk;
    logic                  aresetn;
    logic                  power_on_reset_n;
    logic [4:0]            ev;
    logic [`RCF_AW-1:0]    awaddr, araddr;
    logic [`RCF_DW-1:0]    wdata, rdata;
    logic [`RCF_SW-1:0]    wstrb;
    logic                  awvalid, wvalid, bready, arvalid, rready;
    logic                  awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]            bresp, rresp;
    logic [4:0]            mflags, mistat, mien;
    int                    err_count, checks;

    // event vector uses the status layout: bit 0 pin, 1 power, 2 software, 3 watchdog, 4 lock-up
    rcf_top rcf_top_inst (
        .aclk(aclk), .aresetn(aresetn), .power_on_reset_n(power_on_reset_n),
        .cpu_lockup_rst(ev[`RCF_F_LOCK]), .watchdog_rst(ev[`RCF_F_WDG]),
        .software_rst(ev[`RCF_F_SW]), .brownout_rst(ev[`RCF_F_PWR]),
        .external_reset_pin_n(~ev[`RCF_F_PIN]),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq)
    );

    // 40 MHz clock
    initial aclk = 1'b0;
    always #12.5 aclk = ~aclk;

    task automatic print_verdict();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // a handshake that never comes ends the run as a mismatch
    task automatic hang(input string what);
        err_count++;
        $display("CHECK FAILED %s expected handshake seen none", what);
        print_verdict();
    endtask

    // address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int n;
        logic awt, wt, aw_left, w_left;
        n = 0;
        aw_left = 1'b1;
        w_left = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_left || w_left) begin
            @(negedge aclk);
            awt = (awready === 1'b1);
            wt = (wready === 1'b1);
            @(posedge aclk);
            if (aw_left && awt) begin
                awvalid <= 1'b0;
                aw_left = 1'b0;
            end
            if (w_left && wt) begin
                wvalid <= 1'b0;
                w_left = 1'b0;
            end
            if (++n > 50) hang("write");
        end
        n = 0;
        do begin
            @(negedge aclk);
            if (++n > 50) hang("bresp");
        end while (bvalid !== 1'b1);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic art;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            art = (arready === 1'b1);
            @(posedge aclk);
            if (++n > 50) hang("raddr");
        end while (!art);
        arvalid <= 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            if (++n > 50) hang("rdata");
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        `CHK(nm, e, d)
        `CHK({nm, " resp"}, er, r)
    endtask

    task automatic wr_chk(input string nm, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        axi_wr(a, d, s, r);
        `CHK({nm, " resp"}, er, r)
    endtask

    // flags at 30:26, everything else reads zero
    function automatic logic [31:0] cause_word(input logic [4:0] f);
        return {1'b0, f, 26'h0};
    endfunction

    task automatic chk_cause();
        rd_chk("cause", `RCF_OFS_CAUSE, cause_word(mflags), `RCF_RESP_OKAY);
    endtask

    // only bit 23 set, reserved positions written as zero
    task automatic remove();
        wr_chk("remove", `RCF_OFS_CAUSE, 32'h00800000, 4'hf, `RCF_RESP_OKAY);
        mflags = 5'h00;
    endtask

    // one-cycle reset event; every event also marks the pin flag
    task automatic pulse(input logic [4:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 5'h00;
        if (m != 5'h00) begin
            mflags |= m | 5'h01;
            mistat |= m;
        end
        @(negedge aclk);
        `CHK("irq", |(mistat & mien), irq)
    endtask

    task automatic do_reset(input logic por);
        @(posedge aclk);
        aresetn <= 1'b0;
        power_on_reset_n <= ~por;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        power_on_reset_n <= 1'b1;
        mistat = 5'h00;
        mien = 5'h00;
        if (por) mflags = 5'h03;
    endtask

    // overall run limit
    initial begin
        repeat (50000) @(posedge aclk);
        hang("run");
    end

    initial begin
        logic [4:0] m;
        logic [4:0] d5;
        {aresetn, power_on_reset_n, ev, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {mflags, mistat, mien} = {5'h03, 10'h0};
        err_count = 0;
        checks = 0;
        void'($urandom(32'h776b64c0));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        power_on_reset_n <= 1'b1;
        chk_cause();
        rd_chk("ien", `RCF_OFS_IEN, 32'h0, `RCF_RESP_OKAY);
        remove();
        chk_cause();
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            chk_cause();
            remove();
        end
        // flags accumulate and ignore direct writes or a remove bit whose byte lane is not strobed
        pulse(5'h08);
        pulse(5'h04);
        wr_chk("flags", `RCF_OFS_CAUSE, 32'h7c000000, 4'hf, `RCF_RESP_OKAY);
        wr_chk("lane", `RCF_OFS_CAUSE, 32'h00800000, 4'hb, `RCF_RESP_OKAY);
        chk_cause();
        do_reset(1'b0);
        chk_cause();
        rd_chk("unmapped", 8'h40, 32'h0, `RCF_RESP_SLVERR);
        wr_chk("unmapped", 8'h40, 32'hffffffff, 4'hf, `RCF_RESP_SLVERR);
        rd_chk("iclr", `RCF_OFS_ICLR, 32'h0, `RCF_RESP_OKAY);
        wr_chk("istat", `RCF_OFS_ISTAT, 32'h1f, 4'hf, `RCF_RESP_OKAY);
        rd_chk("istat", `RCF_OFS_ISTAT, 32'h0, `RCF_RESP_OKAY);
        wr_chk("ien", `RCF_OFS_IEN, 32'h1f, 4'hf, `RCF_RESP_OKAY);
        mien = 5'h1f;
        rd_chk("ien", `RCF_OFS_IEN, 32'h1f, `RCF_RESP_OKAY);
        // random events mixed with reads, removes, interrupt clears and masks
        repeat (60) begin
            m = 5'($urandom_range(0, 31));
            d5 = 5'($urandom);
            pulse(m);
            case ($urandom_range(0, 3))
                0: chk_cause();
                1: remove();
                2: begin
                    wr_chk("iclr", `RCF_OFS_ICLR, {27'h0, d5}, 4'hf, `RCF_RESP_OKAY);
                    mistat &= ~d5;
                end
                default: begin
                    wr_chk("ien", `RCF_OFS_IEN, {27'h0, d5}, 4'hf, `RCF_RESP_OKAY);
                    mien = d5;
                end
            endcase
            @(posedge aclk);
            @(negedge aclk);
            `CHK("irq", |(mistat & mien), irq)
        end
        rd_chk("istat", `RCF_OFS_ISTAT, {27'h0, mistat}, `RCF_RESP_OKAY);
        chk_cause();
        // power-on reset mid-run reloads power and pin flags
        do_reset(1'b1);
        chk_cause();
        rd_chk("ien", `RCF_OFS_IEN, 32'h0, `RCF_RESP_OKAY);
        print_verdict();
    end
endmodule
